// File: iaad_pkg.sv
// Constants, types and helpers for the integer add and byte-align datapath
//
// Summary of operation
// (RULE_01) Trapping immediate add forms 33-bit sum, flags overflow
// (RULE_02) Overflow keeps destination; else sign-extended sum written
// (RULE_03) Trapping immediate add decoded from major 001000
// (RULE_04) Release six never executes trapping immediate add
// (RULE_05) Non-word source operands give undefined results
// (RULE_06) Wrapping immediate add decoded from major 001001
// (RULE_07) Wrapping immediate add writes sign-extended low word
// (RULE_08) Wrapping adds never raise integer overflow
// (RULE_09) PC-relative add: major 111011, bits 20..19 zero
// (RULE_10) PC-relative add: immediate shifted two, plus PC
// (RULE_11) PC-relative sum sign-extended like virtual addresses
// (RULE_12) PC-relative add exists only in release six
// (RULE_13) Register wrapping add: special major, function 100001
// (RULE_14) Register wrapping add writes sign-extended low word
// (RULE_15) Word align: extended major, function 100000
// (RULE_16) Dword align: extended major, function 100100
// (RULE_17) Word align ORs shifted low words, sign-extends
// (RULE_18) Dword align ORs two 64-bit logical shifts
// (RULE_19) Dword align traps when 64-bit operations disabled
// (RULE_20) Every pointer defined; zero pointer copies second source
// (RULE_21) Tools should avoid align with zero pointer
// (RULE_22) Exception suppresses write-back in same cycle
package iaad_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int XLEN = 64; // Register width
  localparam int WLEN = 32; // Word width
  localparam int REG_W = 5; // Register index width
  localparam int BP_W = 3; // Widest byte pointer
  localparam int SHAMT_W = 7; // Shift amount in bits, up to 64
  // Implemented virtual address bits; a plain default
  localparam int VA_BITS = 48;

  ////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RA_HI = 25;
  localparam int RA_LO = 21;
  localparam int RB_HI = 20;
  localparam int RB_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int SH_HI = 10;
  localparam int SH_LO = 6;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int IMM16_HI = 15;
  localparam int IMM19_HI = 18;
  localparam int PCSUB_HI = 20;
  localparam int PCSUB_LO = 19;
  localparam int WSUB_LO = 8; // Word align sub-op is 10..8
  localparam int DSUB_LO = 9; // Dword align sub-op is 10..9
  localparam int WBP_HI = 7; // Word pointer 7..6
  localparam int DBP_HI = 8; // Dword pointer 8..6
  localparam int BP_LO = 6;

  ////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [5:0] MAJ_SPECIAL = 6'h00;
  localparam logic [5:0] MAJ_IMM_TRAP = 6'h08;
  localparam logic [5:0] MAJ_IMM_WRAP = 6'h09;
  localparam logic [5:0] MAJ_EXTENDED = 6'h1f;
  localparam logic [5:0] MAJ_PC_REL = 6'h3b;
  localparam logic [5:0] FN_REG_WRAP = 6'h21;
  localparam logic [5:0] FN_WORD_SHUF = 6'h20;
  localparam logic [5:0] FN_DWORD_SHUF = 6'h24;
  localparam logic [2:0] SUB_WORD_ALIGN = 3'h2;
  localparam logic [1:0] SUB_DWORD_ALIGN = 2'h1;
  localparam logic [1:0] SUB_PC_REL_ADD = 2'h0;
  localparam logic [4:0] SHAMT_ZERO = 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // Shift and byte constants
  localparam int PC_IMM_SHIFT = 2;
  localparam int BYTE_SH = 3; // Bytes to bits
  localparam logic [SHAMT_W-1:0] WORD_BITS = 7'h20;
  localparam logic [SHAMT_W-1:0] DWORD_BITS = 7'h40;

  // Operation chosen by decode
  typedef enum logic [2:0] {
    OP_NONE,
    OP_IMM_TRAP,
    OP_IMM_WRAP,
    OP_PC_REL,
    OP_REG_WRAP,
    OP_WORD_ALIGN,
    OP_DWORD_ALIGN
  } iaad_op_t;

  // Sign-extend a word to a register
  function automatic logic [XLEN-1:0] iaad_sext32(input logic [WLEN-1:0] w);
    iaad_sext32 = {{(XLEN-WLEN){w[WLEN-1]}}, w};
  endfunction : iaad_sext32

  // Sign-extend an address from the top implemented bit
  function automatic logic [XLEN-1:0] iaad_sext_va(input logic [XLEN-1:0] a);
    iaad_sext_va = {{(XLEN-VA_BITS){a[VA_BITS-1]}}, a[VA_BITS-1:0]};
  endfunction : iaad_sext_va

endpackage : iaad_pkg

// File: iaad_align.sv
// Byte-align funnel shifter for word and doubleword forms
`timescale 1ns/1ps
module iaad_align (
  // Operands
  input wire logic [iaad_pkg::XLEN-1:0] i_src_a,
  input wire logic [iaad_pkg::XLEN-1:0] i_src_b,
  // Control
  input wire logic [iaad_pkg::BP_W-1:0] i_byte_ptr,
  input wire logic i_dword,
  // Result
  output logic [iaad_pkg::XLEN-1:0] o_result
);
  import iaad_pkg::*;

  logic [SHAMT_W-1:0] lsh; // Left shift in bits
  logic [SHAMT_W-1:0] rsh; // Right shift in bits
  logic [WLEN-1:0] word_res; // Word form before extension
  logic [XLEN-1:0] dword_res; // Doubleword form

  ////////////////////////////////////////////////////////////////////////
  // Shift amounts; a full-width right shift yields zero, so a zero
  // pointer falls out as a copy of the second source with no special case
  always_comb begin
    lsh = SHAMT_W'({i_byte_ptr, BYTE_SH'(0)});
    if (i_dword) begin
      rsh = DWORD_BITS - lsh; // RULE_18
    end else begin
      lsh = SHAMT_W'({i_byte_ptr[1:0], BYTE_SH'(0)});
      rsh = WORD_BITS - lsh; // RULE_17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Funnel both halves and merge
  always_comb begin
    word_res = (i_src_b[WLEN-1:0] << lsh) | (i_src_a[WLEN-1:0] >> rsh); // RULE_17
    dword_res = (i_src_b << lsh) | (i_src_a >> rsh); // RULE_18
    if (i_dword) begin
      o_result = dword_res;
    end else begin
      o_result = iaad_sext32(word_res); // RULE_17
    end
  end

endmodule : iaad_align

// File: iaad_datapath.sv
// Integer add and byte-align execution datapath, one registered stage
`timescale 1ns/1ps
module iaad_datapath (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Issue from decode
  input wire logic i_valid,
  input wire logic [iaad_pkg::WLEN-1:0] i_instr,
  input wire logic [iaad_pkg::XLEN-1:0] i_pc,
  input wire logic [iaad_pkg::XLEN-1:0] i_src_a,
  input wire logic [iaad_pkg::XLEN-1:0] i_src_b,
  // Context
  input wire logic i_release6,
  input wire logic i_dword_ops_en,
  // Write-back
  output logic o_wb_valid,
  output logic [iaad_pkg::REG_W-1:0] o_wb_reg,
  output logic [iaad_pkg::XLEN-1:0] o_wb_data,
  // Exceptions
  output logic o_exc_valid,
  output logic o_exc_overflow,
  output logic o_exc_reserved,
  // Not an instruction of this unit
  output logic o_unclaimed
);
  import iaad_pkg::*;

  // Decoded fields
  logic [5:0] opc;
  logic [5:0] fn;
  logic [REG_W-1:0] ra_idx;
  logic [REG_W-1:0] rb_idx;
  logic [REG_W-1:0] rd_idx;
  logic [4:0] shamt;
  logic [XLEN-1:0] imm16_x; // Sign-extended 16-bit immediate
  logic [XLEN-1:0] imm19_x; // Shifted, sign-extended 19-bit immediate
  logic [BP_W-1:0] bp_word;
  logic [BP_W-1:0] bp_dword;

  // Decode result
  iaad_op_t op;
  logic [REG_W-1:0] dest_idx;

  // Arithmetic
  logic [WLEN:0] trap_sum; // 33-bit trapping sum
  logic trap_ovf;
  logic [WLEN-1:0] wrap_imm_sum;
  logic [WLEN-1:0] wrap_reg_sum;
  logic [XLEN-1:0] pc_sum;
  logic [XLEN-1:0] align_res;

  // Next-stage values
  logic wb_d;
  logic [XLEN-1:0] data_d;
  logic ovf_d;
  logic ri_d;
  logic uncl_d;

  // Registered outputs
  logic wb_q;
  logic [REG_W-1:0] reg_q;
  logic [XLEN-1:0] data_q;
  logic ovf_q;
  logic ri_q;
  logic uncl_q;

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  always_comb begin
    opc = i_instr[OPC_HI:OPC_LO];
    fn = i_instr[FN_HI:FN_LO];
    ra_idx = i_instr[RA_HI:RA_LO]; // RULE_03
    rb_idx = i_instr[RB_HI:RB_LO]; // RULE_06
    rd_idx = i_instr[RD_HI:RD_LO]; // RULE_13
    shamt = i_instr[SH_HI:SH_LO];
    imm16_x = {{(XLEN-IMM16_HI-1){i_instr[IMM16_HI]}},
               i_instr[IMM16_HI:0]}; // RULE_07
    imm19_x = {{(XLEN-IMM19_HI-1-PC_IMM_SHIFT){i_instr[IMM19_HI]}},
               i_instr[IMM19_HI:0], PC_IMM_SHIFT'(0)}; // RULE_10
    bp_word = {1'b0, i_instr[WBP_HI:BP_LO]}; // RULE_15
    bp_dword = i_instr[DBP_HI:BP_LO]; // RULE_16
  end

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode; release gates which opcodes belong here
  always_comb begin
    op = OP_NONE;
    dest_idx = rd_idx;
    unique case (opc)
      MAJ_IMM_TRAP: begin
        // Reassigned in release six: left to other units
        if (!i_release6) begin // RULE_04
          op = OP_IMM_TRAP; // RULE_03
          dest_idx = rb_idx;
        end
      end
      MAJ_IMM_WRAP: begin
        op = OP_IMM_WRAP; // RULE_06
        dest_idx = rb_idx;
      end
      MAJ_PC_REL: begin
        if (i_release6 &&
            i_instr[PCSUB_HI:PCSUB_LO] == SUB_PC_REL_ADD) begin // RULE_12
          op = OP_PC_REL; // RULE_09
          dest_idx = ra_idx;
        end
      end
      MAJ_SPECIAL: begin
        if (fn == FN_REG_WRAP && shamt == SHAMT_ZERO) begin
          op = OP_REG_WRAP; // RULE_13
        end
      end
      MAJ_EXTENDED: begin
        if (i_release6 && fn == FN_WORD_SHUF &&
            i_instr[SH_HI:WSUB_LO] == SUB_WORD_ALIGN) begin
          op = OP_WORD_ALIGN; // RULE_15
        end else if (i_release6 && fn == FN_DWORD_SHUF &&
                     i_instr[SH_HI:DSUB_LO] == SUB_DWORD_ALIGN) begin
          op = OP_DWORD_ALIGN; // RULE_16
        end
      end
      default: begin
        op = OP_NONE; // Other majors belong elsewhere
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Adders. Only the low word of a word source is used; an operand that
  // is not a proper sign-extended word gives an arbitrary result.
  always_comb begin
    trap_sum = {i_src_a[WLEN-1], i_src_a[WLEN-1:0]}
             + imm16_x[WLEN:0]; // RULE_01 RULE_05
    trap_ovf = trap_sum[WLEN] != trap_sum[WLEN-1]; // RULE_01
    wrap_imm_sum = i_src_a[WLEN-1:0] + imm16_x[WLEN-1:0]; // RULE_07 RULE_08
    wrap_reg_sum = i_src_a[WLEN-1:0] + i_src_b[WLEN-1:0]; // RULE_14 RULE_08
    pc_sum = iaad_sext_va(i_pc + imm19_x); // RULE_10 RULE_11
  end

  // Shared funnel shifter for both align forms
  iaad_align u_align (
    .i_src_a(i_src_a),
    .i_src_b(i_src_b),
    .i_byte_ptr(op == OP_DWORD_ALIGN ? bp_dword : bp_word),
    .i_dword(op == OP_DWORD_ALIGN),
    .o_result(align_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // Result and exception selection
  always_comb begin
    wb_d = 1'b0;
    data_d = data_q; // Hold data when nothing is written
    ovf_d = 1'b0;
    ri_d = 1'b0;
    uncl_d = i_valid && op == OP_NONE;
    if (i_valid) begin
      unique case (op)
        OP_IMM_TRAP: begin
          if (trap_ovf) begin
            ovf_d = 1'b1; // RULE_01 RULE_22
          end else begin
            wb_d = 1'b1; // RULE_02
            data_d = iaad_sext32(trap_sum[WLEN-1:0]); // RULE_02
          end
        end
        OP_IMM_WRAP: begin
          wb_d = 1'b1; // RULE_08
          data_d = iaad_sext32(wrap_imm_sum); // RULE_07
        end
        OP_PC_REL: begin
          wb_d = 1'b1; // RULE_11
          data_d = pc_sum; // RULE_10
        end
        OP_REG_WRAP: begin
          wb_d = 1'b1; // RULE_08
          data_d = iaad_sext32(wrap_reg_sum); // RULE_14
        end
        OP_WORD_ALIGN: begin
          wb_d = 1'b1;
          data_d = align_res; // RULE_17 RULE_20
        end
        OP_DWORD_ALIGN: begin
          if (!i_dword_ops_en) begin
            ri_d = 1'b1; // RULE_19 RULE_22
          end else begin
            wb_d = 1'b1;
            data_d = align_res; // RULE_18 RULE_20
          end
        end
        OP_NONE: begin
          wb_d = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-back strobe and destination; frozen while enable is low
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wb_q <= 1'b0;
      reg_q <= SHAMT_ZERO;
    end else if (i_clk_en) begin
      wb_q <= wb_d; // RULE_22
      reg_q <= dest_idx;
    end
  end

  // Result word
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= '0;
    end else if (i_clk_en) begin
      data_q <= data_d;
    end
  end

  // Exception flags, same edge as the suppressed write-back
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ovf_q <= 1'b0;
      ri_q <= 1'b0;
      uncl_q <= 1'b0;
    end else if (i_clk_en) begin
      ovf_q <= ovf_d; // RULE_22
      ri_q <= ri_d; // RULE_22
      uncl_q <= uncl_d;
    end
  end

  // Output drive
  assign o_wb_valid = wb_q;
  assign o_wb_reg = reg_q;
  assign o_wb_data = data_q;
  assign o_exc_overflow = ovf_q;
  assign o_exc_reserved = ri_q;
  assign o_exc_valid = ovf_q | ri_q; // RULE_22
  assign o_unclaimed = uncl_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Issue qualified with enable, per operation
  logic iss;
  assign iss = i_valid && i_clk_en;

  // Reference sums rebuilt from the raw instruction fields
  logic [WLEN-1:0] chk_imm_sum;
  logic [WLEN-1:0] chk_reg_sum;
  logic [WLEN-1:0] chk_b_lo;
  assign chk_imm_sum = i_src_a[WLEN-1:0] +
                       {{(WLEN-IMM16_HI-1){i_instr[IMM16_HI]}},
                        i_instr[IMM16_HI:0]};
  assign chk_reg_sum = i_src_a[WLEN-1:0] + i_src_b[WLEN-1:0];
  assign chk_b_lo = i_src_b[WLEN-1:0];

  property p_trap_ovf;
    iss && opc == MAJ_IMM_TRAP && !i_release6 &&
    ($signed(i_src_a[WLEN-1:0]) + $signed(imm16_x) > 64'sh7fffffff ||
     $signed(i_src_a[WLEN-1:0]) + $signed(imm16_x) < -64'sh80000000)
    |=> o_exc_overflow && o_exc_valid && !o_wb_valid;
  endproperty
  a_trap_ovf: assert property (p_trap_ovf) // RULE_01
    else $error("trapping add overflow not flagged");

  property p_trap_ok;
    iss && opc == MAJ_IMM_TRAP && !i_release6 && !trap_ovf
    |=> o_wb_valid && o_wb_reg == $past(rb_idx) &&
        o_wb_data == iaad_sext32($past(chk_imm_sum));
  endproperty
  a_trap_ok: assert property (p_trap_ok) // RULE_02
    else $error("trapping add result wrong");

  property p_exc_blocks_wb;
    o_exc_valid |-> !o_wb_valid && $stable(o_wb_data);
  endproperty
  a_exc_blocks_wb: assert property (p_exc_blocks_wb) // RULE_22
    else $error("write-back alongside exception");

  property p_r6_no_trap;
    iss && opc == MAJ_IMM_TRAP && i_release6
    |=> o_unclaimed && !o_wb_valid && !o_exc_valid;
  endproperty
  a_r6_no_trap: assert property (p_r6_no_trap) // RULE_04
    else $error("trapping add executed in release six");

  property p_wrap_no_ovf;
    iss && (opc == MAJ_IMM_WRAP ||
            (opc == MAJ_SPECIAL && fn == FN_REG_WRAP && shamt == SHAMT_ZERO))
    |=> o_wb_valid && !o_exc_overflow &&
        o_wb_data[XLEN-1:WLEN] == {(XLEN-WLEN){o_wb_data[WLEN-1]}};
  endproperty
  a_wrap_no_ovf: assert property (p_wrap_no_ovf) // RULE_08
    else $error("wrapping add trapped or not sign-extended");

  property p_pc_relative_major;
    iss && opc == MAJ_PC_REL && i_instr[PCSUB_HI:PCSUB_LO] == SUB_PC_REL_ADD
    |=> (o_wb_valid == $past(i_release6)) && !o_exc_valid &&
        (!o_wb_valid || o_wb_data[1:0] == $past(i_pc[1:0]));
  endproperty
  a_pc_relative_major: assert property (p_pc_relative_major) // RULE_12
    else $error("pc-relative add gating or alignment wrong");

  property p_dword_byte_align_ri;
    iss && op == OP_DWORD_ALIGN && !i_dword_ops_en
    |=> o_exc_reserved && !o_wb_valid ##1
        (!o_exc_reserved || $past(iss) || !$past(i_clk_en));
  endproperty
  a_dword_byte_align_ri: assert property (p_dword_byte_align_ri) // RULE_19
    else $error("dword align did not trap when disabled");

  property p_bp_zero_copy;
    iss && op == OP_DWORD_ALIGN && i_dword_ops_en && bp_dword == 3'h0
    |=> o_wb_valid && o_wb_data == $past(i_src_b);
  endproperty
  a_bp_zero_copy: assert property (p_bp_zero_copy) // RULE_20
    else $error("zero pointer did not copy second source");

  property p_word_zero_copy;
    iss && op == OP_WORD_ALIGN && bp_word == '0
    |=> o_wb_valid && o_wb_data == iaad_sext32($past(chk_b_lo));
  endproperty
  a_word_zero_copy: assert property (p_word_zero_copy) // RULE_20
    else $error("word align zero pointer not a copy");

  property p_reg_wrap_sum;
    iss && opc == MAJ_SPECIAL && fn == FN_REG_WRAP && shamt == SHAMT_ZERO
    |=> o_wb_reg == $past(rd_idx) &&
        o_wb_data == iaad_sext32($past(chk_reg_sum));
  endproperty
  a_reg_wrap_sum: assert property (p_reg_wrap_sum) // RULE_14
    else $error("register wrapping add result wrong");

  property p_one_answer;
    iss |=> $onehot({o_wb_valid, o_exc_valid, o_unclaimed});
  endproperty
  a_one_answer: assert property (p_one_answer) // RULE_22
    else $error("issue did not give exactly one answer");

  property p_freeze;
    !i_clk_en |=> $stable(o_wb_data) && $stable(o_wb_valid) &&
                  $stable(o_exc_valid);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with enable low");

endmodule : iaad_datapath

// File: iaad_regfile_model.sv
// Register file model feeding operands and taking write-backs
`timescale 1ns/1ps
module iaad_regfile_model (
  // Clock
  input wire logic i_ref_clk,
  // Preload from the bench
  input wire logic i_ld_en,
  input wire logic [iaad_pkg::REG_W-1:0] i_ld_idx,
  input wire logic [iaad_pkg::XLEN-1:0] i_ld_val,
  // Instruction being issued
  input wire logic [iaad_pkg::WLEN-1:0] i_instr,
  // Write-back from the datapath
  input wire logic i_wb_valid,
  input wire logic [iaad_pkg::REG_W-1:0] i_wb_reg,
  input wire logic [iaad_pkg::XLEN-1:0] i_wb_data,
  // Operands
  output logic [iaad_pkg::XLEN-1:0] o_src_a,
  output logic [iaad_pkg::XLEN-1:0] o_src_b
);
  import iaad_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Storage, left unknown so a stray read shows up
  logic [XLEN-1:0] regs_q [32];

  // Read ports follow the issued fields with no delay
  assign o_src_a = regs_q[i_instr[RA_HI:RA_LO]];
  assign o_src_b = regs_q[i_instr[RB_HI:RB_LO]];

  ////////////////////////////////////////////////////////////////////////
  // Preload wins; a same-edge read still sees the old value
  always_ff @(posedge i_ref_clk) begin
    if (i_ld_en) begin
      regs_q[i_ld_idx] <= i_ld_val;
    end else if (i_wb_valid) begin
      regs_q[i_wb_reg] <= i_wb_data;
    end
  end
endmodule : iaad_regfile_model

// File: int_add_align_datapath_tb_top.sv
// Self-checking bench for the integer add and byte-align datapath
`timescale 1ns/1ps
module int_add_align_datapath_tb_top;
  import iaad_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // One table row: m is {release6, dword enable, kind}
  // Kind: 0 write-back, 1 overflow, 2 reserved, 3 unclaimed
  typedef struct {
    logic [31:0] ins;
    logic [63:0] pc;
    logic [63:0] a;
    logic [63:0] b;
    logic [3:0] m;
    logic [4:0] rg;
    logic [63:0] d;
  } iaad_row_t;

  localparam int NROW = 21;
  // Zero-pointer rows go against the advice to tools on purpose
  iaad_row_t rows [NROW] = '{
    '{32'h24220001, 64'h0, 64'h7fffffff,
      64'h0, 4'hc, 5'h02, 64'hffffffff80000000},
    '{32'h2422ffff, 64'h0, 64'h0,
      64'h0, 4'h4, 5'h02, 64'hffffffffffffffff},
    '{32'h20220001, 64'h0, 64'h7fffffff,
      64'h0, 4'h5, 5'h02, 64'h0},
    '{32'h2022ffff, 64'h0, 64'hffffffff80000000,
      64'h0, 4'h5, 5'h02, 64'h0},
    '{32'h20220005, 64'h0, 64'hfffffffffffffffe,
      64'h0, 4'h4, 5'h02, 64'h3},
    '{32'h20220005, 64'h0, 64'h0,
      64'h0, 4'hf, 5'h02, 64'h0},
    '{32'h00221821, 64'h0, 64'h7fffffff,
      64'h1, 4'hc, 5'h03, 64'hffffffff80000000},
    '{32'h00221821, 64'h0, 64'hffffffffffffffff,
      64'hffffffffffffffff, 4'h4, 5'h03, 64'hfffffffffffffffe},
    '{32'h00221861, 64'h0, 64'h1,
      64'h1, 4'hf, 5'h03, 64'h0},
    '{32'hec640000, 64'h400000, 64'h0,
      64'h0, 4'hc, 5'h03, 64'h300000},
    '{32'hec600001, 64'h7ffffffffffc, 64'h0,
      64'h0, 4'hc, 5'h03, 64'hffff800000000000},
    '{32'hec600001, 64'h0, 64'h0,
      64'h0, 4'h7, 5'h03, 64'h0},
    '{32'h7c221a60, 64'h0, 64'hffffffffaabbccdd,
      64'h11223344, 4'hc, 5'h03, 64'h223344aa},
    '{32'h7c221ae0, 64'h0, 64'hffffffffaabbccdd,
      64'h11223388, 4'hc, 5'h03, 64'hffffffff88aabbcc},
    '{32'h7c221a20, 64'h0, 64'hffffffffaabbccdd,
      64'hffffffff80000001, 4'hc, 5'h03, 64'hffffffff80000001},
    '{32'h7c221ae4, 64'h0, 64'h0123456789abcdef,
      64'hfedcba9876543210, 4'hc, 5'h03, 64'h9876543210012345},
    '{32'h7c221a24, 64'h0, 64'h0123456789abcdef,
      64'hfedcba9876543210, 4'hc, 5'h03, 64'hfedcba9876543210},
    '{32'h7c221be4, 64'h0, 64'h0123456789abcdef,
      64'hfedcba9876543210, 4'hc, 5'h03, 64'h100123456789abcd},
    '{32'h7c221ae4, 64'h0, 64'h1,
      64'h1, 4'ha, 5'h03, 64'h0},
    '{32'h7c221a60, 64'h0, 64'h1,
      64'h1, 4'h7, 5'h03, 64'h0},
    '{32'hfc000000, 64'h0, 64'h1,
      64'h1, 4'hf, 5'h03, 64'h0}
  };

  ////////////////////////////////////////////////////////////////////////
  // Stimulus, all given values at time zero, and observed signals
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic clk_en = 1'h1;
  logic valid = 1'h0;
  logic [31:0] instr = 32'h0;
  logic [63:0] pc = 64'h0;
  logic rel6 = 1'h0;
  logic dw_en = 1'h0;
  logic ld_en = 1'h0;
  logic [4:0] ld_idx = 5'h0;
  logic [63:0] ld_val = 64'h0;
  logic [63:0] src_a;
  logic [63:0] src_b;
  logic wb_valid;
  logic [4:0] wb_reg;
  logic [63:0] wb_data;
  logic exc_valid;
  logic exc_ovf;
  logic exc_res;
  logic unclaimed;
  logic [1:0] kd;
  int bad_count = 0;
  int n_checks = 0;

  // 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  iaad_datapath uut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_clk_en(clk_en),
    .i_valid(valid), .i_instr(instr), .i_pc(pc),
    .i_src_a(src_a), .i_src_b(src_b),
    .i_release6(rel6), .i_dword_ops_en(dw_en),
    .o_wb_valid(wb_valid), .o_wb_reg(wb_reg), .o_wb_data(wb_data),
    .o_exc_valid(exc_valid), .o_exc_overflow(exc_ovf),
    .o_exc_reserved(exc_res), .o_unclaimed(unclaimed)
  );

  iaad_regfile_model u_regs (
    .i_ref_clk(ref_clk), .i_ld_en(ld_en), .i_ld_idx(ld_idx),
    .i_ld_val(ld_val), .i_instr(instr), .i_wb_valid(wb_valid),
    .i_wb_reg(wb_reg), .i_wb_data(wb_data),
    .o_src_a(src_a), .o_src_b(src_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Comparisons, one per kind of result
  task automatic check_flag(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check_flag

  task automatic check_reg(input logic [4:0] e);
    n_checks++;
    if (wb_reg !== e) begin
      bad_count++;
      $display("ERROR wb_reg expected %h seen %h", e, wb_reg);
    end
  endtask : check_reg

  task automatic check_data(input logic [63:0] e);
    n_checks++;
    if (wb_data !== e) begin
      bad_count++;
      $display("ERROR wb_data expected %h seen %h", e, wb_data);
    end
  endtask : check_data

  ////////////////////////////////////////////////////////////////////////
  // Drivers: preload one register, or issue one instruction
  task automatic load(input logic [4:0] idx, input logic [63:0] v);
    @(posedge ref_clk);
    ld_en <= 1'h1;
    ld_idx <= idx;
    ld_val <= v;
  endtask : load

  task automatic issue(input logic [31:0] ins, input logic [63:0] p,
                       input logic r6, input logic dw);
    @(posedge ref_clk);
    ld_en <= 1'h0;
    valid <= 1'h1;
    instr <= ins;
    pc <= p;
    rel6 <= r6;
    dw_en <= dw;
  endtask : issue

  // Last request taken at the next edge; look once it has landed
  task automatic retire;
    @(posedge ref_clk);
    valid <= 1'h0;
    @(negedge ref_clk);
  endtask : retire

  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog: the whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    // Table of ordinary cases
    for (int i = 0; i < NROW; i++) begin
      load(5'h01, rows[i].a);
      load(5'h02, rows[i].b);
      issue(rows[i].ins, rows[i].pc, rows[i].m[3], rows[i].m[2]);
      retire();
      kd = rows[i].m[1:0];
      check_flag("wb_valid", kd == 2'h0, wb_valid);
      check_flag("exc_overflow", kd == 2'h1, exc_ovf);
      check_flag("exc_reserved", kd == 2'h2, exc_res);
      check_flag("exc_valid", kd inside {2'h1, 2'h2}, exc_valid);
      check_flag("unclaimed", kd == 2'h3, unclaimed);
      if (kd == 2'h0) begin
        check_reg(rows[i].rg);
        check_data(rows[i].d);
      end
    end
    // Back to back, then a read of the written-back register
    load(5'h01, 64'h5);
    load(5'h02, 64'h10);
    issue(32'h24220001, 64'h0, 1'h1, 1'h1);
    issue(32'h00221821, 64'h0, 1'h1, 1'h1);
    @(negedge ref_clk);
    check_data(64'h6);
    retire();
    check_data(64'h15);
    issue(32'h00221821, 64'h0, 1'h1, 1'h1);
    retire();
    check_data(64'hb);
    // Overflow pulse held while the clock enable is low
    load(5'h01, 64'h7fffffff);
    issue(32'h20220001, 64'h0, 1'h0, 1'h1);
    @(posedge ref_clk);
    valid <= 1'h0;
    clk_en <= 1'h0;
    repeat (3) begin
      @(negedge ref_clk);
      check_flag("exc_overflow", 1'h1, exc_ovf);
      check_flag("wb_valid", 1'h0, wb_valid);
    end
    @(posedge ref_clk);
    clk_en <= 1'h1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check_flag("exc_overflow", 1'h0, exc_ovf);
    // Reset in mid-run clears outputs, first edge after release works
    load(5'h01, 64'h5);
    issue(32'h24220001, 64'h0, 1'h1, 1'h1);
    @(posedge ref_clk);
    rst <= 1'h1;
    @(negedge ref_clk);
    check_flag("wb_valid", 1'h0, wb_valid);
    check_flag("exc_valid", 1'h0, exc_valid);
    check_flag("unclaimed", 1'h0, unclaimed);
    check_data(64'h0);
    @(posedge ref_clk);
    rst <= 1'h0;
    retire();
    check_flag("wb_valid", 1'h1, wb_valid);
    check_data(64'h6);
    finish_test();
  end
endmodule : int_add_align_datapath_tb_top
